//--- src/pcp_pkg.sv
// Package with the port widths, reset values and pin positions of the third port
package pcp_pkg;
	localparam int unsigned PORT_WIDTH = 8;
	localparam logic [7:0] DIRECTION_RESET = 8'h_FF;
	localparam logic [7:0] LATCH_RESET = 8'h_00;
	localparam int unsigned OSC_OUT_PIN = 0;
	localparam int unsigned OSC_IN_PIN = 1;
	localparam int unsigned CCP_PIN = 2;
	localparam int unsigned SERIAL_CLK_PIN = 3;
endpackage : pcp_pkg

//--- src/pcp_port.sv
// Third general-purpose port: output latches, direction word and peripheral overrides
`timescale 1ns/1ps
// What this block does
// (R01) Zero write to data or latch clears latches
// (R02) Direction bit one means input, zero output
// (R03) Enabled aux oscillator overrides pin 0 direction
// (R04) Enabled aux oscillator overrides pin 1 direction
// (R05) Software sets pin 3 input for serial clock
// (R06) Direction reads return stored bits despite overrides
// (R07) Power-on reset makes every pin an input
// (R08) Latch reads return latched value, not pins
module pcp_port (
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	input wire logic port_pin_data_write,
	input wire logic port_output_latch_write,
	input wire logic port_direction_write,
	input wire logic [7:0] write_data,
	output logic [7:0] port_pin_data,
	output logic [7:0] port_output_latch,
	output logic [7:0] port_direction,
	input wire logic aux_osc_enable,
	input wire logic aux_osc_output,
	output logic aux_osc_input,
	output logic aux_timer_clock_in,
	input wire logic sync_serial_port_clk_enable,
	input wire logic sync_serial_port_clk_out,
	input wire logic sync_serial_port_clk_oe,
	output logic sync_serial_port_clk_in,
	input wire logic capture_compare_enable,
	input wire logic capture_compare_pin,
	output logic capture_compare_in,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe
);
	logic [7:0] latch_q;
	logic [7:0] latch_d;
	logic [7:0] direction_q;
	logic [7:0] direction_d;
	logic [7:0] pin_level;
	logic latch_write_taken;
	logic direction_write_taken;
	logic osc_owns_pins;
	logic serial_owns_clock;
	logic compare_owns_value;

	// Both write paths land on the one latch; the latch path wins a tie
	always_comb begin
		latch_d = latch_q;
		if (port_output_latch_write) begin
			latch_d = write_data; // [R01]
		end else if (port_pin_data_write) begin
			latch_d = write_data; // [R01]
		end
	end

	always_comb begin
		direction_d = direction_q;
		if (port_direction_write) begin
			direction_d = write_data; // [R02]
		end
	end

	// A write while the clock enable is low is dropped, not deferred
	assign latch_write_taken = clock_enable & (port_output_latch_write | port_pin_data_write);
	assign direction_write_taken = clock_enable & port_direction_write;

	// Overrides act on the drive only; the stored direction word is never touched
	assign osc_owns_pins = aux_osc_enable;
	assign compare_owns_value = capture_compare_enable;
	// Serial port owns pin 3 only while software leaves its direction bit set
	assign serial_owns_clock = sync_serial_port_clk_enable &
		direction_q[pcp_pkg::SERIAL_CLK_PIN]; // [R05]

	// Per pin: stored bits, two-flop synchroniser, owner selection and drive register
	for (genvar i = 0; i < pcp_pkg::PORT_WIDTH; i++) begin : g_pin
		logic latch_bit_q;
		logic direction_bit_q;
		logic meta_q;
		logic sync_q;
		logic value_d;
		logic enable_d;
		logic value_q;
		logic enable_q;
		logic owned_by_osc_out;
		logic owned_by_osc_in;
		logic owned_by_serial;
		logic owned_by_compare;

		assign owned_by_osc_out = (i == pcp_pkg::OSC_OUT_PIN) && osc_owns_pins;
		assign owned_by_osc_in = (i == pcp_pkg::OSC_IN_PIN) && osc_owns_pins;
		assign owned_by_serial = (i == pcp_pkg::SERIAL_CLK_PIN) && serial_owns_clock;
		assign owned_by_compare = (i == pcp_pkg::CCP_PIN) && compare_owns_value;

		always_ff @(posedge clock) begin
			if (reset) begin
				latch_bit_q <= pcp_pkg::LATCH_RESET[i];
			end else if (latch_write_taken) begin
				latch_bit_q <= latch_d[i]; // [R08]
			end
		end

		always_ff @(posedge clock) begin
			if (reset) begin
				direction_bit_q <= pcp_pkg::DIRECTION_RESET[i]; // [R07]
			end else if (direction_write_taken) begin
				direction_bit_q <= direction_d[i];
			end
		end

		// Pins are asynchronous to the core clock; only sync_q is read by logic
		always_ff @(posedge clock) begin
			if (reset) begin
				meta_q <= 1'b0;
			end else if (clock_enable) begin
				meta_q <= pin_in[i];
			end
		end

		always_ff @(posedge clock) begin
			if (reset) begin
				sync_q <= 1'b0;
			end else if (clock_enable) begin
				sync_q <= meta_q;
			end
		end

		always_comb begin
			value_d = latch_bit_q;
			if (owned_by_compare) begin
				value_d = capture_compare_pin;
			end
			if (owned_by_osc_out) begin
				value_d = aux_osc_output;
			end
			if (owned_by_serial) begin
				value_d = sync_serial_port_clk_out;
			end
		end

		always_comb begin
			enable_d = ~direction_bit_q; // [R02]
			if (owned_by_osc_out) begin
				enable_d = 1'b1; // [R03]
			end
			if (owned_by_osc_in) begin
				enable_d = 1'b0; // [R04]
			end
			if (owned_by_serial) begin
				enable_d = sync_serial_port_clk_oe; // [R05]
			end
		end

		// Drive is registered so the pins never glitch while owners change
		always_ff @(posedge clock) begin
			if (reset) begin
				value_q <= pcp_pkg::LATCH_RESET[i];
			end else if (clock_enable) begin
				value_q <= value_d;
			end
		end

		always_ff @(posedge clock) begin
			if (reset) begin
				enable_q <= ~pcp_pkg::DIRECTION_RESET[i]; // [R07]
			end else if (clock_enable) begin
				enable_q <= enable_d;
			end
		end

		assign latch_q[i] = latch_bit_q;
		assign direction_q[i] = direction_bit_q;
		assign pin_level[i] = sync_q;
		assign pin_out[i] = value_q;
		assign pin_oe[i] = enable_q;
	end

	assign port_pin_data = pin_level;
	assign port_output_latch = latch_q; // [R08]
	assign port_direction = direction_q; // [R06]
	// Peripheral inputs see the same synchronised level as a port read
	assign aux_osc_input = pin_level[pcp_pkg::OSC_IN_PIN];
	assign aux_timer_clock_in = pin_level[pcp_pkg::OSC_OUT_PIN];
	assign sync_serial_port_clk_in = pin_level[pcp_pkg::SERIAL_CLK_PIN];
	assign capture_compare_in = pin_level[pcp_pkg::CCP_PIN];
endmodule : pcp_port

//--- verif/pcp_board.sv
// Board model that resolves the port pins
`timescale 1ns/1ps
module pcp_board (input wire logic [7:0] pin_out, pin_oe, ext, output logic [7:0] pin_in);
	// A released pin shows the board level, never the last drive
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : pcp_board

//--- verif/pcp_port_checker.sv
// Assertions on the port block
`timescale 1ns/1ps
module pcp_checker (input wire logic clock, reset, clock_enable, port_output_latch_write,
	port_pin_data_write, port_direction_write, aux_osc_enable,
	input wire logic [7:0] write_data, port_output_latch, port_direction, pin_oe);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	property p_lat; clock_enable && port_output_latch_write
		|=> port_output_latch == $past(write_data); endproperty
	a_lat: assert property (p_lat) else $error("latch write lost");
	property p_oe; clock_enable |=> pin_oe[7:4] == ~$past(port_direction[7:4]); endproperty
	a_oe: assert property (p_oe) else $error("direction not on pins");
	property p_osc; clock_enable && aux_osc_enable |=> pin_oe[1:0] == 2'h1; endproperty
	a_osc: assert property (p_osc) else $error("oscillator override");
	property p_data; clock_enable && port_pin_data_write && !port_output_latch_write
		|=> port_output_latch == $past(write_data); endproperty
	a_data: assert property (p_data) else $error("data path write lost");
	property p_dir; clock_enable && port_direction_write
		|=> port_direction == $past(write_data); endproperty
	a_dir: assert property (p_dir) else $error("direction write lost");
	property p_frz; !clock_enable
		|=> $stable(port_output_latch) && $stable(port_direction); endproperty
	a_frz: assert property (p_frz) else $error("state moved while frozen");
	property p_rst; @(posedge clock) disable iff (1'b0) reset
		|=> port_direction == pcp_pkg::DIRECTION_RESET && pin_oe == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset not all inputs");
	cover property (aux_osc_enable);
	cover property (port_output_latch_write);
	cover property (pin_oe == 8'h30);
endmodule : pcp_checker
bind pcp_port pcp_checker chk (.*);

//--- verif/pcp_port_test.sv
// Directed test of the port block
`timescale 1ns/1ps
module pcp_port_test;
	logic clock = 1'h0, reset = 1'h1, clock_enable = 1'h1, port_pin_data_write = 1'h0;
	logic port_output_latch_write = 1'h0, port_direction_write = 1'h0, aux_osc_enable = 1'h0;
	logic aux_osc_output = 1'h0, sync_serial_port_clk_enable = 1'h0, sync_serial_port_clk_oe = 1'h0;
	logic sync_serial_port_clk_out = 1'h0, capture_compare_enable = 1'h0, capture_compare_pin = 1'h0;
	logic aux_osc_input, aux_timer_clock_in, sync_serial_port_clk_in, capture_compare_in;
	logic [7:0] write_data = 8'h00, ext = 8'hFF, pin_in, pin_out, pin_oe;
	logic [7:0] port_pin_data, port_output_latch, port_direction;
	int n_fail = 0, checked = 0, cyc = 0;
	pcp_port dut (.*);
	pcp_board board (.*);
	always #10 clock = ~clock;
	task complete_run;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	task ck(input string s, input logic [7:0] e, g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask : ck
	// Strobe order is data path, latch path, direction
	task wr(input logic [2:0] k, input logic [7:0] d);
		@(posedge clock);
		{port_pin_data_write, port_output_latch_write, port_direction_write} <= k;
		write_data <= d;
		@(posedge clock);
		{port_pin_data_write, port_output_latch_write, port_direction_write} <= 3'h0;
		repeat (3) @(posedge clock);
		#1;
	endtask : wr
	always @(posedge clock) if (++cyc == 400) begin
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'h0;
		#1;
		ck("dir", 8'hFF, port_direction);
		ck("oe", 8'h00, pin_oe);
		for (int k = 2; k <= 4; k += 2) begin
			wr(k[2:0], 8'hA5);
			ck("latch", 8'hA5, port_output_latch);
			wr(k[2:0], 8'h00);
			ck("latch", 8'h00, port_output_latch);
		end
		wr(3'h1, 8'hCF);
		ck("oe", 8'h30, pin_oe);
		wr(3'h2, 8'h30);
		ck("out", 8'h30, pin_out);
		ck("pins", 8'hFF, port_pin_data);
		ck("latch", 8'h30, port_output_latch);
		@(posedge clock);
		clock_enable <= 1'h0;
		wr(3'h2, 8'h5A);
		ck("frozen", 8'h30, port_output_latch);
		@(posedge clock);
		clock_enable <= 1'h1;
		{capture_compare_enable, capture_compare_pin} <= 2'h3;
		ext <= 8'h00;
		wr(3'h1, 8'hC9);
		ck("oe", 8'h36, pin_oe);
		ck("out", 8'h34, pin_out);
		ck("pins", 8'h34, port_pin_data);
		ck("ccp in", 8'h01, capture_compare_in);
		@(posedge clock);
		{aux_osc_enable, aux_osc_output, sync_serial_port_clk_enable} <= 3'h7;
		{sync_serial_port_clk_out, sync_serial_port_clk_oe} <= 2'h3;
		ext <= 8'h02;
		wr(3'h0, 8'h00);
		ck("oe", 8'h3D, pin_oe);
		ck("out", 8'h3D, pin_out);
		ck("pins", 8'h3F, port_pin_data);
		ck("osc in", 8'h01, aux_osc_input);
		ck("tmr in", 8'h01, aux_timer_clock_in);
		ck("sck in", 8'h01, sync_serial_port_clk_in);
		ck("dir", 8'hC9, port_direction);
		@(posedge clock);
		reset <= 1'h1;
		@(posedge clock);
		reset <= 1'h0;
		#1;
		ck("dir", 8'hFF, port_direction);
		ck("oe", 8'h00, pin_oe);
		ck("latch", 8'h00, port_output_latch);
		complete_run;
	end
endmodule : pcp_port_test
